//--- verilog/ccl_pkg.sv
// constants, types and field layouts of the condition code logic
// Contract
// - extend copies carry, else kept or specified
// - negative follows result top bit
// - zero set when sized result is zero
// - overflow set when result unrepresentable
// - carry on add carry or subtract borrow
// - negate: V=Dm and Rm, C=Dm or Rm
// - negate-with-extend zero only clears, accumulates
// - arith left: V on top-bit change, C=X=last out
// - other left shifts/rotates: V cleared, C=last top out
// - zero count shift/rotate: V=C=0, X kept
// - zero count rotate-extend: C=X, V=0, X kept
// - four-bit condition decoded into flag formula
// - code 0000 true, 0001 false, no branch
// - 0111 true on Z, 0110 on not Z
// - 1000 overflow clear, 1001 overflow set
// - 1100 N equals V, 1101 differs
// - 1110 N==V and not Z, 1111 complement
package ccl_pkg;

  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam int         ADDR_W        = 6;
  localparam int         DATA_W        = 32;
  localparam int         STRB_W        = DATA_W / 8;
  localparam logic [5:0] OFF_OPERAND   = 6'h00;
  localparam logic [5:0] OFF_COMMAND   = 6'h04;
  localparam logic [5:0] OFF_FLAGS     = 6'h08;
  localparam logic [5:0] OFF_RESULT    = 6'h0C;
  localparam logic [5:0] OFF_COND      = 6'h10;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CMD_OP_LSB      = 0;
  localparam int CMD_SIZE_LSB    = 4;
  localparam int CMD_COUNT_LSB   = 8;
  localparam int COUNT_W         = 6;
  localparam int MAX_COUNT       = 2 ** COUNT_W;
  localparam int COND_CODE_LSB   = 0;
  localparam int COND_TRUE_BIT   = 8;
  localparam int COND_BRANCH_BIT = 9;
  localparam int FLAGS_W         = 5;

  // ************************************************************
  // operand sizes
  // ************************************************************
  localparam int          MSB_BYTE  = 7;
  localparam int          MSB_WORD  = 15;
  localparam int          MSB_LONG  = 31;
  localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
  localparam logic [31:0] MASK_WORD = 32'h0000_FFFF;
  localparam logic [31:0] MASK_LONG = 32'hFFFF_FFFF;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    negate_op              = 4'h0,
    negate_with_extend_op  = 4'h1,
    arith_shift_left_op    = 4'h2,
    arith_shift_right_op   = 4'h3,
    logic_shift_left_op    = 4'h4,
    logic_shift_right_op   = 4'h5,
    rotate_left_op         = 4'h6,
    rotate_right_op        = 4'h7,
    rotate_extend_left_op  = 4'h8,
    rotate_extend_right_op = 4'h9
  } ccl_op_e;

  typedef enum logic [1:0] {
    size_byte = 2'h0,
    size_word = 2'h1,
    size_long = 2'h2
  } ccl_size_e;

  typedef enum logic [3:0] {
    cond_always              = 4'h0,
    cond_never               = 4'h1,
    cond_unsigned_higher     = 4'h2,
    cond_unsigned_lower_same = 4'h3,
    cond_carry_clear         = 4'h4,
    cond_carry_set           = 4'h5,
    cond_not_equal           = 4'h6,
    cond_equal               = 4'h7,
    cond_overflow_clear      = 4'h8,
    cond_overflow_set        = 4'h9,
    cond_plus                = 4'hA,
    cond_minus               = 4'hB,
    cond_signed_ge           = 4'hC,
    cond_signed_lt           = 4'hD,
    cond_signed_gt           = 4'hE,
    cond_signed_le           = 4'hF
  } ccl_cond_e;

  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } ccl_flags_s;

  typedef struct packed {
    logic [3:0]         op;
    logic [1:0]         size;
    logic [COUNT_W-1:0] count;
  } ccl_cmd_s;

  typedef struct packed {
    logic [31:0] result;
    ccl_flags_s  flags;
  } ccl_exec_s;

  localparam ccl_flags_s  FLAGS_RESET   = 5'h00;
  localparam logic [31:0] OPERAND_RESET = 32'h0000_0000;
  localparam logic [3:0]  COND_RESET    = 4'h0;

endpackage

//--- verilog/ccl_cond_eval.sv
// condition test evaluator over the current flags
`timescale 1ns/1ns
module ccl_cond_eval
(
  input  wire logic              [3:0] code_i,
  input  wire ccl_pkg::ccl_flags_s     flags_i,
  output logic                         cond_true_o,
  output logic                         branch_ok_o
);

  always_comb
  begin
    branch_ok_o = (code_i != ccl_pkg::cond_never);
    unique case (code_i)
      ccl_pkg::cond_always:              cond_true_o = 1'b1;
      ccl_pkg::cond_never:               cond_true_o = 1'b0;
      ccl_pkg::cond_unsigned_higher:     cond_true_o = !flags_i.c && !flags_i.z;
      ccl_pkg::cond_unsigned_lower_same: cond_true_o = flags_i.c || flags_i.z;
      ccl_pkg::cond_carry_clear:         cond_true_o = !flags_i.c;
      ccl_pkg::cond_carry_set:           cond_true_o = flags_i.c;
      ccl_pkg::cond_not_equal:           cond_true_o = !flags_i.z;
      ccl_pkg::cond_equal:               cond_true_o = flags_i.z;
      ccl_pkg::cond_overflow_clear:      cond_true_o = !flags_i.v;
      ccl_pkg::cond_overflow_set:        cond_true_o = flags_i.v;
      ccl_pkg::cond_plus:                cond_true_o = !flags_i.n;
      ccl_pkg::cond_minus:               cond_true_o = flags_i.n;
      ccl_pkg::cond_signed_ge:           cond_true_o = (flags_i.n == flags_i.v);
      ccl_pkg::cond_signed_lt:           cond_true_o = (flags_i.n != flags_i.v);
      ccl_pkg::cond_signed_gt:
        cond_true_o = (flags_i.n == flags_i.v) && !flags_i.z;
      ccl_pkg::cond_signed_le:
        cond_true_o = flags_i.z || (flags_i.n != flags_i.v);
    endcase
  end

endmodule

//--- verilog/ccl_top.sv
// condition code logic with an AXI4-Lite register slave
`timescale 1ns/1ns
module ccl_top
(
  input  wire logic                         sys_clk_i,
  input  wire logic                         reset_i,
  input  wire logic [ccl_pkg::ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [ccl_pkg::DATA_W-1:0]   s_axi_wdata_i,
  input  wire logic [ccl_pkg::STRB_W-1:0]   s_axi_wstrb_i,
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  output logic [1:0]                        s_axi_bresp_o,
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  input  wire logic [ccl_pkg::ADDR_W-1:0]   s_axi_araddr_i,
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  output logic [ccl_pkg::DATA_W-1:0]        s_axi_rdata_o,
  output logic [1:0]                        s_axi_rresp_o,
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i,
  output ccl_pkg::ccl_flags_s               flags_o,
  output logic [ccl_pkg::DATA_W-1:0]        result_o,
  output logic                              cond_true_o,
  output logic                              branch_ok_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic                        awready;
    logic                        wready;
    logic                        arready;
    logic                        aw_held;
    logic [ccl_pkg::ADDR_W-1:0]  aw_addr;
    logic                        w_held;
    logic [ccl_pkg::DATA_W-1:0]  w_data;
    logic [ccl_pkg::STRB_W-1:0]  w_strb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [ccl_pkg::DATA_W-1:0]  rdata;
    logic [ccl_pkg::DATA_W-1:0]  operand;
    logic [ccl_pkg::DATA_W-1:0]  result;
    ccl_pkg::ccl_cmd_s           cmd;
    ccl_pkg::ccl_flags_s         flags;
    logic [3:0]                  cond_code;
    logic                        cond_true;
    logic                        branch_ok;
  } ccl_state_s;

  ccl_state_s state;
  ccl_state_s next_state;
  logic       eval_true;
  logic       eval_branch;

  // ************************************************************
  // condition evaluator
  // ************************************************************
  ccl_cond_eval u_cond_eval
  (
    .code_i      (state.cond_code),
    .flags_i     (state.flags),
    .cond_true_o (eval_true),
    .branch_ok_o (eval_branch)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  // byte-lane merge of a write into a stored word
  function automatic logic [ccl_pkg::DATA_W-1:0] merge_word
  (
    input logic [ccl_pkg::DATA_W-1:0] old_w,
    input logic [ccl_pkg::DATA_W-1:0] new_w,
    input logic [ccl_pkg::STRB_W-1:0] strb
  );
    logic [ccl_pkg::DATA_W-1:0] w;
    w = old_w;
    for (int b = 0; b < ccl_pkg::STRB_W; b++)
      if (strb[b])
        w[b*8 +: 8] = new_w[b*8 +: 8];
    return w;
  endfunction

  function automatic logic [ccl_pkg::DATA_W-1:0] cmd_word(input ccl_pkg::ccl_cmd_s c);
    logic [ccl_pkg::DATA_W-1:0] w;
    w = '0;
    w[ccl_pkg::CMD_OP_LSB +: 4] = c.op;
    w[ccl_pkg::CMD_SIZE_LSB +: 2] = c.size;
    w[ccl_pkg::CMD_COUNT_LSB +: ccl_pkg::COUNT_W] = c.count;
    return w;
  endfunction

  // one operation at its operand size, with its flag effects
  function automatic ccl_pkg::ccl_exec_s exec_op
  (
    input ccl_pkg::ccl_cmd_s   c,
    input logic [31:0]         dst,
    input ccl_pkg::ccl_flags_s f
  );
    logic [31:0]        mask;
    logic [31:0]        v;
    logic [31:0]        prev;
    int                 m;
    logic               out;
    logic               xs;
    logic               vacc;
    logic               left;
    logic               rox;
    logic               rot;
    ccl_pkg::ccl_exec_s e;
    e.flags = f;
    unique case (c.size)
      ccl_pkg::size_byte:
      begin
        m = ccl_pkg::MSB_BYTE;
        mask = ccl_pkg::MASK_BYTE;
      end
      ccl_pkg::size_word:
      begin
        m = ccl_pkg::MSB_WORD;
        mask = ccl_pkg::MASK_WORD;
      end
      default:
      begin
        m = ccl_pkg::MSB_LONG;
        mask = ccl_pkg::MASK_LONG;
      end
    endcase
    v = dst & mask;
    out = 1'b0;
    xs = f.x;
    vacc = 1'b0;
    left = (c.op == ccl_pkg::arith_shift_left_op) || (c.op == ccl_pkg::logic_shift_left_op)
        || (c.op == ccl_pkg::rotate_left_op) || (c.op == ccl_pkg::rotate_extend_left_op);
    rox = (c.op == ccl_pkg::rotate_extend_left_op) || (c.op == ccl_pkg::rotate_extend_right_op);
    rot = (c.op == ccl_pkg::rotate_left_op) || (c.op == ccl_pkg::rotate_right_op);
    if ((c.op == ccl_pkg::negate_op) || (c.op == ccl_pkg::negate_with_extend_op))
    begin
      // negate subtracts from zero, with extend folded in for multiprecision
      v = 32'h0000_0000 - (dst & mask);
      if (c.op == ccl_pkg::negate_with_extend_op)
        v = v - {31'h0000_0000, f.x};
      v = v & mask;
      e.flags.v = dst[m] & v[m];
      e.flags.c = dst[m] | v[m];
      e.flags.x = e.flags.c;
    end
    else
    begin
      for (int i = 0; i < ccl_pkg::MAX_COUNT; i++)
      begin
        if (i < int'(c.count))
        begin
          prev = v;
          if (left)
          begin
            out = prev[m];
            v = prev << 1;
            if (c.op == ccl_pkg::rotate_left_op)
              v[0] = out;
            if (rox)
              v[0] = xs;
            v = v & mask;
            vacc = vacc | (v[m] ^ prev[m]);
          end
          else
          begin
            out = prev[0];
            v = prev >> 1;
            if (c.op == ccl_pkg::arith_shift_right_op)
              v[m] = prev[m];
            if (c.op == ccl_pkg::rotate_right_op)
              v[m] = out;
            if (rox)
              v[m] = xs;
          end
          xs = out;
        end
      end
      if (c.count == '0)
      begin
        e.flags.v = 1'b0;
        e.flags.c = rox ? f.x : 1'b0;
      end
      else
      begin
        e.flags.v = (c.op == ccl_pkg::arith_shift_left_op) ? vacc : 1'b0;
        e.flags.c = out;
        e.flags.x = rot ? f.x : out;
      end
    end
    e.flags.n = v[m];
    if (c.op == ccl_pkg::negate_with_extend_op)
      e.flags.z = f.z & (v == '0);
    else
      e.flags.z = (v == '0);
    e.result = v;
    return e;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic [ccl_pkg::DATA_W-1:0] merged;
    logic [ccl_pkg::DATA_W-1:0] rd;
    logic [ccl_pkg::ADDR_W-3:0] wa;
    logic [ccl_pkg::ADDR_W-3:0] ra;
    ccl_pkg::ccl_exec_s         ex;
    merged = '0;
    rd = '0;
    wa = '0;
    ra = '0;
    ex = '0;
    next_state = state;

    // responses retire on their handshake
    if (state.bvalid && s_axi_bready_i)
      next_state.bvalid = 1'b0;
    if (state.rvalid && s_axi_rready_i)
      next_state.rvalid = 1'b0;

    // write address and data are captured independently
    if (s_axi_awvalid_i && state.awready)
    begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && state.wready)
    begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata_i;
      next_state.w_strb = s_axi_wstrb_i;
    end

    // perform a write once both halves are in and no response is pending
    if (next_state.aw_held && next_state.w_held && !next_state.bvalid)
    begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = ccl_pkg::RESP_OKAY;
      wa = next_state.aw_addr[ccl_pkg::ADDR_W-1:2];
      if (wa == ccl_pkg::OFF_OPERAND[ccl_pkg::ADDR_W-1:2])
      begin
        next_state.operand = merge_word(state.operand, next_state.w_data, next_state.w_strb);
      end
      else if (wa == ccl_pkg::OFF_COMMAND[ccl_pkg::ADDR_W-1:2])
      begin
        // a command write runs the operation on the stored operand
        merged = merge_word(cmd_word(state.cmd), next_state.w_data, next_state.w_strb);
        next_state.cmd.op = merged[ccl_pkg::CMD_OP_LSB +: 4];
        next_state.cmd.size = merged[ccl_pkg::CMD_SIZE_LSB +: 2];
        next_state.cmd.count = merged[ccl_pkg::CMD_COUNT_LSB +: ccl_pkg::COUNT_W];
        if (next_state.cmd.op <= ccl_pkg::rotate_extend_right_op)
        begin
          ex = exec_op(next_state.cmd, state.operand, state.flags);
          next_state.result = ex.result;
          next_state.flags = ex.flags;
        end
        else
        begin
          next_state.bresp = ccl_pkg::RESP_SLVERR;
        end
      end
      else if (wa == ccl_pkg::OFF_FLAGS[ccl_pkg::ADDR_W-1:2])
      begin
        merged = merge_word({27'h0000_000, state.flags}, next_state.w_data, next_state.w_strb);
        next_state.flags = merged[ccl_pkg::FLAGS_W-1:0];
      end
      else if (wa == ccl_pkg::OFF_COND[ccl_pkg::ADDR_W-1:2])
      begin
        merged = merge_word({28'h0000_000, state.cond_code}, next_state.w_data,
                            next_state.w_strb);
        next_state.cond_code = merged[ccl_pkg::COND_CODE_LSB +: 4];
      end
      else if (wa != ccl_pkg::OFF_RESULT[ccl_pkg::ADDR_W-1:2])
      begin
        next_state.bresp = ccl_pkg::RESP_SLVERR;
      end
    end

    // reads
    if (s_axi_arvalid_i && state.arready)
    begin
      ra = s_axi_araddr_i[ccl_pkg::ADDR_W-1:2];
      next_state.rvalid = 1'b1;
      next_state.rresp = ccl_pkg::RESP_OKAY;
      if (ra == ccl_pkg::OFF_OPERAND[ccl_pkg::ADDR_W-1:2])
        rd = state.operand;
      else if (ra == ccl_pkg::OFF_COMMAND[ccl_pkg::ADDR_W-1:2])
        rd = cmd_word(state.cmd);
      else if (ra == ccl_pkg::OFF_FLAGS[ccl_pkg::ADDR_W-1:2])
        rd[ccl_pkg::FLAGS_W-1:0] = state.flags;
      else if (ra == ccl_pkg::OFF_RESULT[ccl_pkg::ADDR_W-1:2])
        rd = state.result;
      else if (ra == ccl_pkg::OFF_COND[ccl_pkg::ADDR_W-1:2])
      begin
        rd[ccl_pkg::COND_CODE_LSB +: 4] = state.cond_code;
        rd[ccl_pkg::COND_TRUE_BIT] = state.cond_true;
        rd[ccl_pkg::COND_BRANCH_BIT] = state.branch_ok;
      end
      else
      begin
        next_state.rresp = ccl_pkg::RESP_SLVERR;
      end
      next_state.rdata = rd;
    end

    // ready flags are registered; awready and wready lower after a capture that stays held, arready after a read capture
    next_state.awready = !next_state.aw_held;
    next_state.wready = !next_state.w_held;
    next_state.arready = !next_state.rvalid;
    next_state.cond_true = eval_true;
    next_state.branch_ok = eval_branch;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state <= '0;
      state.operand <= ccl_pkg::OPERAND_RESET;
      state.flags <= ccl_pkg::FLAGS_RESET;
      state.cond_code <= ccl_pkg::COND_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign s_axi_awready_o = state.awready;
  assign s_axi_wready_o  = state.wready;
  assign s_axi_arready_o = state.arready;
  assign s_axi_bvalid_o  = state.bvalid;
  assign s_axi_bresp_o   = state.bresp;
  assign s_axi_rvalid_o  = state.rvalid;
  assign s_axi_rresp_o   = state.rresp;
  assign s_axi_rdata_o   = state.rdata;
  assign flags_o         = state.flags;
  assign result_o        = state.result;
  assign cond_true_o     = state.cond_true;
  assign branch_ok_o     = state.branch_ok;

endmodule

//--- test/ccl_top_monitor.sv
// checker of the condition outputs of the condition code logic
`timescale 1ns/1ns
module ccl_top_monitor
(
  input wire logic                       sys_clk_i,
  input wire logic                       reset_i,
  input wire logic [ccl_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic                       s_axi_awvalid_i,
  input wire logic                       s_axi_awready_o,
  input wire logic [ccl_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic                       s_axi_wvalid_i,
  input wire logic                       s_axi_wready_o,
  input wire ccl_pkg::ccl_flags_s        flags_o,
  input wire logic                       cond_true_o,
  input wire logic                       branch_ok_o
);
  logic [3:0]          code_q;
  logic [3:0]          pc;
  ccl_pkg::ccl_flags_s pf;
  logic                pr;

  // ************************************************************
  // stored code mirror, state one cycle back
  // ************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    pc <= code_q;
    pf <= flags_o;
    pr <= reset_i;
    if (reset_i)
      code_q <= 4'h0;
    else if (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
             && s_axi_awaddr_i[5:2] == 4'h4)
      code_q <= s_axi_wdata_i[3:0];
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  property p_true_false;
    !pr && pc[3:1] == 3'h0 |-> cond_true_o == !pc[0];
  endproperty
  a_true_false: assert property (p_true_false)
    else $error("always or never code wrong");
  property p_branch;
    !pr |-> branch_ok_o == (pc != 4'h1);
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch ok wrong");
  property p_higher;
    !pr && pc[3:1] == 3'h1 |-> cond_true_o == (pc[0] == (pf.c | pf.z));
  endproperty
  a_higher: assert property (p_higher)
    else $error("higher code wrong");
  property p_carry;
    !pr && pc[3:1] == 3'h2 |-> cond_true_o == (pc[0] == pf.c);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry code wrong");
  property p_equal;
    !pr && pc[3:1] == 3'h3 |-> cond_true_o == (pc[0] == pf.z);
  endproperty
  a_equal: assert property (p_equal)
    else $error("equal code wrong");
  property p_ovf;
    !pr && pc[3:1] == 3'h4 |-> cond_true_o == (pc[0] == pf.v);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow code wrong");
  property p_sign;
    !pr && pc[3:1] == 3'h5 |-> cond_true_o == (pc[0] == pf.n);
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign code wrong");
  property p_ge_lt;
    !pr && pc[3:1] == 3'h6 |-> cond_true_o == (pc[0] == (pf.n ^ pf.v));
  endproperty
  a_ge_lt: assert property (p_ge_lt)
    else $error("ge lt code wrong");
  property p_gt_le;
    !pr && pc[3:1] == 3'h7 |-> cond_true_o == (pc[0] == (pf.z | (pf.n ^ pf.v)));
  endproperty
  a_gt_le: assert property (p_gt_le)
    else $error("gt le code wrong");
endmodule

bind ccl_top ccl_top_monitor u_ccl_top_monitor (.*);

//--- test/testbench.sv
// self-checking bench of the condition code logic
`timescale 1ns/1ns
module testbench;
  logic                sys_clk_i, reset_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic                s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
  logic                s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, cond_true_o, branch_ok_o;
  logic [5:0]          s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0]         s_axi_wdata_i, s_axi_rdata_o, result_o, d;
  logic [3:0]          s_axi_wstrb_i;
  logic [1:0]          s_axi_bresp_o, s_axi_rresp_o, r;
  ccl_pkg::ccl_flags_s flags_o;
  int                  failures, checks;

  ccl_top u_ccl_top (.*);

  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = !sys_clk_i;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task guard(input int n);
    if (n >= 40)
    begin
      failures++;
      complete_run();
    end
  endtask

  task wr(input logic [5:0] a, input logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o)
        s_axi_wvalid_i <= 1'b0;
      n++;
    end
    while (!s_axi_bvalid_o && n < 40);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    @(posedge sys_clk_i);
    guard(n);
  endtask

  task rd(input logic [5:0] a);
    int n;
    n = 0;
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o)
        s_axi_arvalid_i <= 1'b0;
      n++;
    end
    while (!s_axi_rvalid_o && n < 40);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    @(posedge sys_clk_i);
    guard(n);
  endtask

  // flags in, command out, result and flags judged at the ports
  task op(input logic [3:0] o, input logic [1:0] s, input logic [5:0] c, input logic [31:0] v,
          input logic [4:0] fi, input logic [31:0] er, input logic [4:0] ef);
    wr(6'h08, {27'h0, fi});
    wr(6'h00, v);
    wr(6'h04, {18'h0, c, 2'h0, s, o});
    chk(32'(r), 32'h0);
    chk(result_o, er);
    chk(32'(flags_o), 32'(ef));
  endtask

  // condition formula over {x,n,z,v,c}
  function automatic logic ev(input logic [3:0] k, input logic [4:0] f);
    logic b;
    case (k[3:1])
      3'h0: b = 1'b1;
      3'h1: b = !(f[0] | f[2]);
      3'h2: b = !f[0];
      3'h3: b = !f[2];
      3'h4: b = !f[1];
      3'h5: b = !f[3];
      3'h6: b = f[3] == f[1];
      default: b = (f[3] == f[1]) && !f[2];
    endcase
    return b ^ k[0];
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_bus;
    rd(6'h08);
    chk(d, 32'(ccl_pkg::FLAGS_RESET));
    wr(6'h14, 32'h1);
    chk(32'(r), 32'(ccl_pkg::RESP_SLVERR));
    rd(6'h14);
    chk(32'(r), 32'(ccl_pkg::RESP_SLVERR));
    wr(6'h08, 32'h1F);
    rd(6'h08);
    chk(d, 32'h1F);
    wr(6'h0C, 32'hFFFF_FFFF);
    rd(6'h0C);
    chk(d, 32'h0);
    wr(6'h04, 32'hA);
    chk(32'(r), 32'(ccl_pkg::RESP_SLVERR));
    rd(6'h04);
    chk(d, 32'hA);
    wr(6'h00, 32'h1234_5678);
    rd(6'h00);
    chk(d, 32'h1234_5678);
    chk(32'(r), 32'(ccl_pkg::RESP_OKAY));
    $display("t_bus done");
  endtask

  task t_neg;
    op(4'h0, 2'h0, 6'h0, 32'h80, 5'h00, 32'h80, 5'h1B);
    op(4'h0, 2'h2, 6'h0, 32'h0, 5'h00, 32'h0, 5'h04);
    op(4'h0, 2'h1, 6'h0, 32'h0001_0001, 5'h00, 32'hFFFF, 5'h19);
    op(4'h1, 2'h1, 6'h0, 32'h0, 5'h10, 32'hFFFF, 5'h19);
    op(4'h1, 2'h2, 6'h0, 32'h0, 5'h04, 32'h0, 5'h04);
    op(4'h1, 2'h2, 6'h0, 32'h0, 5'h00, 32'h0, 5'h00);
    $display("t_neg done");
  endtask

  task t_shift;
    op(4'h2, 2'h0, 6'h1, 32'h40, 5'h00, 32'h80, 5'h0A);
    op(4'h2, 2'h0, 6'h2, 32'h40, 5'h00, 32'h00, 5'h17);
    op(4'h4, 2'h0, 6'h1, 32'h81, 5'h00, 32'h02, 5'h11);
    op(4'h6, 2'h0, 6'h1, 32'h81, 5'h00, 32'h03, 5'h01);
    op(4'h8, 2'h0, 6'h1, 32'h80, 5'h00, 32'h00, 5'h15);
    op(4'h3, 2'h0, 6'h1, 32'h81, 5'h00, 32'hC0, 5'h19);
    op(4'h5, 2'h0, 6'h1, 32'h01, 5'h00, 32'h00, 5'h15);
    op(4'h7, 2'h0, 6'h1, 32'h01, 5'h00, 32'h80, 5'h09);
    op(4'h9, 2'h0, 6'h1, 32'h01, 5'h00, 32'h00, 5'h15);
    op(4'h5, 2'h2, 6'h20, 32'hFFFF_FFFF, 5'h00, 32'h0, 5'h15);
    for (int o = 2; o < 8; o++)
      op(4'(o), 2'h2, 6'h0, 32'h8000_0000, 5'h13, 32'h8000_0000, 5'h18);
    op(4'h8, 2'h0, 6'h0, 32'h01, 5'h12, 32'h01, 5'h11);
    op(4'h9, 2'h0, 6'h0, 32'h01, 5'h03, 32'h01, 5'h00);
    $display("t_shift done");
  endtask

  task t_cond;
    logic [4:0] pat [5];
    pat = '{5'h00, 5'h0A, 5'h05, 5'h08, 5'h02};
    foreach (pat[i])
      for (int k = 0; k < 16; k++)
      begin
        wr(6'h08, {27'h0, pat[i]});
        wr(6'h10, 32'(k));
        chk(32'(cond_true_o), 32'(ev(4'(k), pat[i])));
        chk(32'(branch_ok_o), 32'(k != 1));
      end
    // last setting: flags v only, code 1111, so true and branch ok both read back set
    rd(6'h10);
    chk(d, 32'h0000_030F);
    $display("t_cond done");
  endtask

  initial
  begin
    failures = 0;
    checks = 0;
    reset_i = 1'b1;
    s_axi_awaddr_i = 6'h00;
    s_axi_araddr_i = 6'h00;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'hF;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h00;
    repeat (12) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    t_bus();
    t_neg();
    t_shift();
    t_cond();
    complete_run();
  end
endmodule
